// File: design/sec_counter_pkg.sv
// shared constants and types for the dual seconds counter with three-wire port
package sec_counter_pkg;
   // widths of the command byte, the counters and the trim field
   localparam int CMD_W = 8;
   localparam int CNT_W = 32;
   localparam int TRIM_W = 3;
   // command byte field positions
   localparam int CMD_SEL_CONT_BIT = 7;
   localparam int CMD_SEL_PWR_BIT = 6;
   localparam int CMD_TRIM_HI_BIT = 5;
   localparam int CMD_TRIM_LO_BIT = 3;
   localparam int CMD_CLR_CONT_BIT = 2;
   localparam int CMD_CLR_PWR_BIT = 1;
   localparam int CMD_DIR_READ_BIT = 0;
   // serial frame positions, counted in rising serial clock edges
   localparam logic [5:0] CMD_BITS = 6'h08;
   localparam logic [5:0] LAST_CMD_EDGE = 6'h07;
   localparam logic [5:0] LAST_DATA_EDGE = 6'h27;
   // values after reset, and the nominal and stop trim codes
   localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
   localparam logic [TRIM_W-1:0] TRIM_RESET = 3'h3;
   localparam logic [TRIM_W-1:0] TRIM_NOMINAL = 3'h3;
   localparam logic [TRIM_W-1:0] TRIM_STOP = 3'h0;
   // crystal edges per second at nominal trim, and edges moved per trim step
   localparam int XTAL_HZ = 32768;
   localparam int TRIM_STEP_EDGES = 4;
   localparam int PRESCALE_W = 16;
   // pin synchroniser depth
   localparam int SYNC_STAGES = 3;
   // phase of the serial port within a frame
   typedef enum logic [1:0] {
      PH_CMD = 2'b00,
      PH_READ = 2'b01,
      PH_WRITE = 2'b10,
      PH_IGNORE = 2'b11
   } link_phase_t;
endpackage

// File: design/pin_sync3.sv
// three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] stable_q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // chain: the first stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else if (ce) begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts only when two settled stages agree, filtering one-cycle glitches
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stable_q <= '0;
      end else if (ce) begin
         stable_q <= (s2_q == s3_q) ? s3_q : stable_q;
      end
   end
endmodule

// File: design/dual_seconds_counter_serial.sv
// dual seconds counter: timekeeping on core_clk, three-wire port on the serial clock
`timescale 1ns/1ps
module dual_seconds_counter_serial
   import sec_counter_pkg::*;
#(
   parameter int XTAL_EDGES_PER_SEC = XTAL_HZ,
   parameter int TRIM_STEP = TRIM_STEP_EDGES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic sclk,
   input wire logic xfer_en,
   input wire logic dq_in,
   output logic dq_out,
   output logic dq_oe,
   input wire logic main_supply_ok,
   input wire logic xtal_clk,
   output logic backup_mode
);
   // core domain: timekeeping, counters, trim and the decode of finished frames
   // everything here runs on core_clk and, except link_init_q, stops while ce is low
   // the crystal and the supply are pins, seen only through the synchroniser
   logic link_init_q;
   logic port_en_q;
   logic backup_mode_q;
   logic xtal_prev_q;
   logic xfer_prev_q;
   logic sec_tick_q;
   logic [PRESCALE_W-1:0] prescale_q;
   logic [PRESCALE_W-1:0] period;
   logic [TRIM_W-1:0] trim_q;
   logic [CNT_W-1:0] cont_q;
   logic [CNT_W-1:0] pwr_q;
   logic [CNT_W-1:0] shadow_cont_q;
   logic [CNT_W-1:0] shadow_pwr_q;
   logic cmd_seen_q;
   logic wr_seen_q;
   // synchronised copies
   logic xtal_s;
   logic supply_s;
   logic xfer_s;
   logic cmd_seq_s;
   logic wr_seq_s;
   // decoded core events
   logic frame_end;
   logic new_cmd;
   logic clr_cont;
   logic clr_pwr;
   logic load_trim;
   logic wr_load;

   // link domain: registers clocked by the host serial clock
   // results that the core reads are kept here until the next command replaces them
   // the frame part is held in reset between frames, so it starts clean each time
   logic frame_rst_n;
   link_phase_t phase_q;
   logic [5:0] bit_cnt_q;
   logic [CMD_W-1:0] cmd_sr_q;
   logic [CMD_W-1:0] cmd_q;
   logic [CMD_W-1:0] cmd_next;
   logic cmd_seq_q;
   logic [CNT_W-1:0] rd_snap_q;
   logic [CNT_W-1:0] wr_buf_q;
   logic wr_seq_q;
   logic drive_q;
   logic dq_out_q;
   logic [4:0] data_idx;

   // all asynchronous pins and the two link toggles cross through one synchroniser
   // the toggles flip once per finished command or write, so a level crossing is enough
   // the words that go with a toggle stand still long before the toggle is seen
   // limitation: the crystal must stay well below core_clk/4 or edges are lost
   pin_sync3 #(
      .W(5)
   ) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .async_in({xtal_clk, main_supply_ok, xfer_en, cmd_seq_q, wr_seq_q}),
      .stable_q({xtal_s, supply_s, xfer_s, cmd_seq_s, wr_seq_s})
   );

   // reset for link-side result registers; the serial clock may be stopped, so it acts asynchronously
   always_ff @(posedge core_clk) begin
      link_init_q <= rst;
   end

   // supply watch: losing main supply enters backup and closes the port
   // both flags come from the same filtered level, so they never disagree
   // the reset value assumes no supply until the synchroniser has seen one
   always_ff @(posedge core_clk) begin
      if (rst) begin
         port_en_q <= 1'b0;
         backup_mode_q <= 1'b1;
      end else if (ce) begin
         port_en_q <= supply_s;
         backup_mode_q <= ~supply_s;
      end
   end

   // seconds per trim: each step above nominal shortens the second, each below lengthens it
   // limitation: the period must fit PRESCALE_W bits for every trim value
   // the stop code is handled in the prescaler, not here
   always_comb begin
      period = PRESCALE_W'(XTAL_EDGES_PER_SEC + int'(TRIM_NOMINAL) * TRIM_STEP - int'(trim_q) * TRIM_STEP);
   end

   // crystal edge prescaler producing the internal 1 Hz tick
   // the tick lasts one core cycle and is shared by both counters
   // a stopped oscillator keeps the partial count, so restarting loses under one second
   // compare with >= so that shortening the period mid-count cannot run past it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         xtal_prev_q <= 1'b0;
         prescale_q <= '0;
         sec_tick_q <= 1'b0;
      end else if (ce) begin
         xtal_prev_q <= xtal_s;
         sec_tick_q <= 1'b0;
         if (trim_q == TRIM_STOP) begin
            prescale_q <= prescale_q;
         end else if (xtal_s && !xtal_prev_q) begin
            if (prescale_q >= period - PRESCALE_W'(1)) begin
               prescale_q <= '0;
               sec_tick_q <= 1'b1;
            end else begin
               prescale_q <= prescale_q + PRESCALE_W'(1);
            end
         end
      end
   end

   // frame end and command decoding; link registers read here are stable once their toggle is seen
   // a frame shorter than the command byte never flips the toggle and so has no effect
   // clears and trim act at frame end, a write as soon as its last bit is in
   // trim loads with both selects set, whatever the direction bit says
   always_comb begin
      frame_end = xfer_prev_q && !xfer_s;
      new_cmd = frame_end && (cmd_seq_s != cmd_seen_q);
      clr_cont = new_cmd && !cmd_q[CMD_SEL_CONT_BIT] && !cmd_q[CMD_SEL_PWR_BIT]
         && cmd_q[CMD_CLR_CONT_BIT];
      clr_pwr = new_cmd && !cmd_q[CMD_SEL_CONT_BIT] && !cmd_q[CMD_SEL_PWR_BIT]
         && cmd_q[CMD_CLR_PWR_BIT];
      load_trim = new_cmd && cmd_q[CMD_SEL_CONT_BIT] && cmd_q[CMD_SEL_PWR_BIT];
      wr_load = wr_seq_s != wr_seen_q;
   end

   // bookkeeping of seen toggles and the transfer enable history
   // the command toggle is only consumed at frame end, so a clear waits for the enable to fall
   // the write toggle is consumed at once, giving a one-cycle load strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         xfer_prev_q <= 1'b0;
         cmd_seen_q <= 1'b0;
         wr_seen_q <= 1'b0;
      end else if (ce) begin
         xfer_prev_q <= xfer_s;
         if (frame_end) begin
            cmd_seen_q <= cmd_seq_s;
         end
         wr_seen_q <= wr_seq_s;
      end
   end

   // trim register
   // reset value is the nominal code, so the oscillator runs from the start
   // only the three trim bits of the command are kept
   always_ff @(posedge core_clk) begin
      if (rst) begin
         trim_q <= TRIM_RESET;
      end else if (ce && load_trim) begin
         trim_q <= cmd_q[CMD_TRIM_HI_BIT:CMD_TRIM_LO_BIT];
      end
   end

   // continuous counter: clear beats write, write beats the tick
   // a tick that meets a write is lost on purpose: the host set the value it wanted
   // this counter ignores the supply flag and keeps running in backup
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cont_q <= CNT_RESET;
      end else if (ce) begin
         if (clr_cont) begin
            cont_q <= CNT_RESET;
         end else if (wr_load && cmd_q[CMD_SEL_CONT_BIT]) begin
            cont_q <= wr_buf_q;
         end else if (sec_tick_q) begin
            cont_q <= cont_q + CNT_W'(1);
         end
      end
   end

   // powered counter: ticks count only while main supply is present
   // it keeps its value through backup and resumes when the supply returns
   // same priority as the continuous counter
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pwr_q <= CNT_RESET;
      end else if (ce) begin
         if (clr_pwr) begin
            pwr_q <= CNT_RESET;
         end else if (wr_load && cmd_q[CMD_SEL_PWR_BIT]) begin
            pwr_q <= wr_buf_q;
         end else if (sec_tick_q && supply_s) begin
            pwr_q <= pwr_q + CNT_W'(1);
         end
      end
   end

   // shadows freeze while a frame is open, so the link side samples a quiet word
   // trade-off: a read shows the count at the frame's start, a few cycles old
   // the freeze covers the whole command byte, far longer than the sync delay
   always_ff @(posedge core_clk) begin
      if (rst) begin
         shadow_cont_q <= CNT_RESET;
         shadow_pwr_q <= CNT_RESET;
      end else if (ce && !xfer_s) begin
         shadow_cont_q <= cont_q;
         shadow_pwr_q <= pwr_q;
      end
   end

   // serial clock domain: the sequencer, the result registers and the pin driver
   // nothing here sees ce; a stopped host clock simply leaves the port where it is
   // words taken from the core side are frozen while the frame is open

   // port logic is held idle while enable is low or the supply has dropped
   // the enable acts asynchronously, since the host may stop the clock at any time
   // hazard: port_en_q is a core flop; it only changes slowly with the filtered supply
   // so the release of this reset is never close to a serial edge in normal use
   assign frame_rst_n = xfer_en && port_en_q;

   // incoming command byte, least significant bit first
   // the next value is also used to decode the phase at the eighth edge
   always_comb begin
      cmd_next = {dq_in, cmd_sr_q[CMD_W-1:1]};
   end

   // frame sequencer: command, then 32 data clocks, then everything ignored
   // the bit counter counts rising edges from the start of the frame
   // equal select bits mean trim, clear or nothing, and no data phase follows
   // once ignoring, only a new frame brings the sequencer back
   always_ff @(posedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         phase_q <= PH_CMD;
         bit_cnt_q <= '0;
         cmd_sr_q <= '0;
      end else begin
         case (phase_q)
            PH_CMD: begin
               cmd_sr_q <= cmd_next;
               bit_cnt_q <= bit_cnt_q + 6'h01;
               if (bit_cnt_q == LAST_CMD_EDGE) begin
                  if (cmd_next[CMD_SEL_CONT_BIT] == cmd_next[CMD_SEL_PWR_BIT]) begin
                     phase_q <= PH_IGNORE;
                  end else if (cmd_next[CMD_DIR_READ_BIT]) begin
                     phase_q <= PH_READ;
                  end else begin
                     phase_q <= PH_WRITE;
                  end
               end
            end
            PH_READ, PH_WRITE: begin
               bit_cnt_q <= bit_cnt_q + 6'h01;
               if (bit_cnt_q == LAST_DATA_EDGE) begin
                  phase_q <= PH_IGNORE;
               end
            end
            PH_IGNORE: begin
               bit_cnt_q <= bit_cnt_q;
            end
            default: begin
               phase_q <= PH_IGNORE;
            end
         endcase
      end
   end

   // results kept across frame end for the core side; cleared only by the core reset
   // the frame reset must not touch them, or a clear would vanish as the enable falls
   // a write that is cut short never flips its toggle, so the counter keeps its value
   // the write buffer shifts right, so the first bit lands in bit 0 after 32 edges
   always_ff @(posedge sclk or posedge link_init_q) begin
      if (link_init_q) begin
         cmd_q <= '0;
         cmd_seq_q <= 1'b0;
         rd_snap_q <= CNT_RESET;
         wr_buf_q <= CNT_RESET;
         wr_seq_q <= 1'b0;
      end else begin
         if (phase_q == PH_CMD && bit_cnt_q == LAST_CMD_EDGE) begin
            cmd_q <= cmd_next;
            cmd_seq_q <= ~cmd_seq_q;
            // snapshot taken at the end of the command so a tick cannot garble the read
            rd_snap_q <= cmd_next[CMD_SEL_CONT_BIT] ? shadow_cont_q : shadow_pwr_q;
         end
         if (phase_q == PH_WRITE) begin
            wr_buf_q <= {dq_in, wr_buf_q[CNT_W-1:1]};
            if (bit_cnt_q == LAST_DATA_EDGE) begin
               wr_seq_q <= ~wr_seq_q;
            end
         end
      end
   end

   // data bit index counted from the first data clock
   // only valid in the read phase, where the counter is 8 to 39
   always_comb begin
      data_idx = 5'(bit_cnt_q - CMD_BITS);
   end

   // read output changes on falling edges; first bit follows the last command bit
   // after the last data edge the phase is ignore, so the next fall stops driving
   // the value is forced low when not reading, so no stale bit shows
   always_ff @(negedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         drive_q <= 1'b0;
         dq_out_q <= 1'b0;
      end else if (phase_q == PH_READ) begin
         drive_q <= 1'b1;
         dq_out_q <= rd_snap_q[data_idx];
      end else begin
         drive_q <= 1'b0;
         dq_out_q <= 1'b0;
      end
   end

   // the pin floats while the clock is high, leaving the host free to end the frame then
   // the enable is gated by the clock itself, the one output not taken straight from a flop
   assign dq_oe = drive_q && !sclk;
   assign dq_out = dq_out_q;
   assign backup_mode = backup_mode_q;
endmodule

// File: sim/dual_seconds_counter_serial_properties.sv
// port assertions for the dual seconds counter
`timescale 1ns/1ps
module dual_seconds_counter_serial_properties
   import sec_counter_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic xfer_en,
   input wire logic dq_in,
   input wire logic dq_out,
   input wire logic dq_oe,
   input wire logic main_supply_ok,
   input wire logic backup_mode
);
   logic [5:0] edge_n_q = 6'h00;
   logic [7:0] cmd_q = 8'h00;
   logic rd_cmd;
   logic in_data;
   // rising edges in the frame; restarts with the enable, as the port does
   always_ff @(posedge sclk or negedge xfer_en) begin
      if (!xfer_en) begin
         edge_n_q <= 6'h00;
         cmd_q <= 8'h00;
      end else if (edge_n_q != 6'h3F) begin
         edge_n_q <= edge_n_q + 6'h01;
         if (edge_n_q < CMD_BITS) cmd_q <= {dq_in, cmd_q[7:1]};
      end
   end
   assign rd_cmd = cmd_q[0] & (cmd_q[7] ^ cmd_q[6]);
   assign in_data = edge_n_q >= CMD_BITS && edge_n_q <= LAST_DATA_EDGE;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   chk_oe_clock_low: assert property (dq_oe |-> !sclk)
      else $error("pin driven with clock high");
   chk_oe_idle_low: assert property (!xfer_en |-> !dq_oe)
      else $error("pin driven outside frame");
   chk_oe_backup_off: assert property (backup_mode |-> !dq_oe)
      else $error("pin driven in backup");
   chk_oe_data_phase: assert property (dq_oe |-> rd_cmd && in_data)
      else $error("pin driven outside read data");
   chk_read_drive: assert property (xfer_en && !sclk && !backup_mode && rd_cmd && in_data |-> dq_oe)
      else $error("read data not driven");
   chk_out_high_hold: assert property (sclk && $past(sclk) && xfer_en && $past(xfer_en) |-> $stable(dq_out))
      else $error("read data moved with clock high");
   chk_backup_enter: assert property (!main_supply_ok [*8] |-> backup_mode)
      else $error("backup not entered");
   chk_backup_leave: assert property (main_supply_ok [*8] |-> !backup_mode)
      else $error("backup not left");
   cover property ($rose(dq_oe));
   cover property ($rose(backup_mode));
   cover property (edge_n_q == 6'h28 && !rd_cmd);
endmodule

// File: sim/host_port_model.sv
// host side of the three-wire port
`timescale 1ns/1ps
module host_port_model (
   output logic sclk,
   output logic xfer_en,
   output logic dq_in,
   input wire logic dq_out,
   input wire logic dq_oe,
   output logic [31:0] rd_word,
   output logic rd_strobe
);
   logic hdrv = 1'b1;
   logic hbit = 1'b0;
   // a released pin flips every phase so a stale value never reads as good
   assign dq_in = dq_oe ? dq_out : (hdrv ? hbit : ~sclk);
   initial begin
      sclk = 1'b0;
      xfer_en = 1'b0;
      rd_word = '0;
      rd_strobe = 1'b0;
   end
   // one frame, 32 ns clock; the clock stands low between frames
   task automatic frame(input logic [7:0] cmd, input logic [31:0] wd, input int nd);
      logic [47:0] sh;
      logic rd;
      sh = {8'h5A, wd, cmd};
      rd = cmd[0] & (cmd[7] ^ cmd[6]);
      xfer_en = 1'b1;
      #16;
      for (int i = 0; i < 8 + nd; i++) begin
         sclk = 1'b0;
         hdrv = !(rd && i >= 8);
         hbit = sh[i];
         #15;
         if (i >= 8) rd_word = {dq_in, rd_word[31:1]};
         #1 sclk = 1'b1;
         #16;
      end
      xfer_en = 1'b0;
      #16 sclk = 1'b0;
      hdrv = 1'b1;
      rd_strobe = rd && nd == 32;
      #200 rd_strobe = 1'b0;
   endtask
endmodule

// File: sim/dual_seconds_counter_serial_tb_top.sv
// bench: host frames, queued read expectations, timeout
`timescale 1ns/1ps
module dual_seconds_counter_serial_tb_top;
   localparam int PER = 16;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic main_supply_ok = 1'b0;
   logic xtal_clk = 1'b0;
   logic [3:0] xdiv = 4'h0;
   logic sclk, xfer_en, dq_in, dq_out, dq_oe, backup_mode, rd_strobe;
   logic [31:0] rd_word, r1, r2;
   logic [7:0] ctab[5] = '{8'h04, 8'h02, 8'h06, 8'h38, 8'hC4};
   logic [2:0] trims[3] = '{3'h7, 3'h3, 3'h1};
   logic [31:0] exp_q[$];
   int tol_q[$];
   int errors = 0;
   int compares = 0;
   int cyc = 0;
   int per;
   dual_seconds_counter_serial #(.XTAL_EDGES_PER_SEC(PER), .TRIM_STEP(1)) i_dual_seconds_counter_serial (
      .core_clk(core_clk), .rst(rst), .ce(ce), .sclk(sclk), .xfer_en(xfer_en), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .main_supply_ok(main_supply_ok), .xtal_clk(xtal_clk),
      .backup_mode(backup_mode));
   host_port_model i_host_port_model (.sclk(sclk), .xfer_en(xfer_en), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .rd_word(rd_word), .rd_strobe(rd_strobe));
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   // crystal at a sixteenth of the core rate, slow enough for the synchroniser
   always @(posedge core_clk) begin
      xdiv <= xdiv + 4'h1;
      xtal_clk <= xdiv[3];
      cyc++;
      if (cyc == 32000) begin
         errors++;
         wrap_up();
      end
   end
   task automatic send(input logic [7:0] c, input logic [31:0] d, input int nd);
      i_host_port_model.frame(c, d, nd);
   endtask
   task automatic rd_chk(input logic [7:0] c, input logic [31:0] e, input int tl);
      exp_q.push_back(e);
      tol_q.push_back(tl);
      send(c, 32'h0, 32);
   endtask
   // counts near a second boundary get a tolerance, everything else is exact
   always @(posedge rd_strobe) begin
      logic [31:0] e;
      int tl;
      e = exp_q.pop_front();
      tl = tol_q.pop_front();
      compares++;
      if (^rd_word === 1'bx || rd_word + tl < e || rd_word > e + tl) begin
         errors++;
         $display("CHECK FAILED %0t read %h expected %h", $time, rd_word, e);
      end
   end
   task automatic wrap_up();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(32'h6C50));
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      main_supply_ok <= 1'b1;
      #200;
      send(8'hC0, 32'h0, 0);
      rd_chk(8'h81, 32'h0, 0);
      rd_chk(8'h41, 32'h0, 0);
      foreach (ctab[k]) begin
         r1 = $urandom();
         r2 = $urandom();
         send(8'h80, r1, 32);
         send(8'h40, r2, 34);
         send(ctab[k], 32'hFFFF_FFFF, 32);
         rd_chk(8'h81, (ctab[k][7:6] == 2'b00 && ctab[k][2]) ? 32'h0 : r1, 0);
         rd_chk(8'h41, (ctab[k][7:6] == 2'b00 && ctab[k][1]) ? 32'h0 : r2, 0);
      end
      send(8'h80, ~r1, 20);
      rd_chk(8'h81, r1, 0);
      foreach (trims[k]) begin
         per = (PER + 3 - trims[k]) * 160;
         send(8'h80, 32'h0, 32);
         send(8'h40, 32'h0, 32);
         send({2'b11, trims[k], 3'h0}, 32'h0, 0);
         if (trims[k] == 3'h1) begin
            #4000;
            @(posedge core_clk) main_supply_ok <= 1'b0;
            #20000;
            compares++;
            if (backup_mode !== 1'b1) begin
               errors++;
               $display("CHECK FAILED %0t backup not entered", $time);
            end
            send(8'h80, 32'hFFFF_FFFF, 32);
            #18500;
            @(posedge core_clk) main_supply_ok <= 1'b1;
            #4000;
         end else begin
            #48000;
         end
         send(8'hC0, 32'h0, 0);
         rd_chk(8'h81, (48500 + per / 2) / per, 1);
         rd_chk(8'h41, ((trims[k] == 3'h1 ? 8500 : 48500) + per / 2) / per, 1);
      end
      send(8'hD8, 32'h0, 0);
      wrap_up();
   end
endmodule
bind dual_seconds_counter_serial dual_seconds_counter_serial_properties i_props (.core_clk(core_clk), .rst(rst),
   .sclk(sclk), .xfer_en(xfer_en), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
   .main_supply_ok(main_supply_ok), .backup_mode(backup_mode));
